// ---- src/twes_event_status.sv ----
// Serial event status, enable and set registers with interrupt request
//
// Overview of operation
// - Any flag set with its enable set drives the interrupt request high.
// - Flags latch regardless of enable; disabled flags raise no request.
// - Registers reachable only from the internal register bus port.
// - Soft reset zeroes all flags; only fresh events after release set them.
// - Bit 6 sets on external outbox read if software had loaded it.
// - Bit 7 sets when an external master writes the incoming mailbox.
// - Bit 14 sets when boot load fails.
// - Bit 15 sets on boot load success or when boot load was disabled.
// - Bit 20 sets when a target access aborts with error.
// - Bit 21 sets on external write-data access, only if writes permitted.
// - Bit 22 sets on external read-data access, only if reads permitted.
// - Bit 23 sets when a target access ends without error.
// - Bit 24 sets on an initiator diagnostic event.
// - Bit 27 sets on arbitration loss after the address phase.
// - Bit 28 sets on clock-low, byte or transaction timeout.
// - Bit 29 sets on a refused address or data byte.
// - Bit 30 sets when the bus arbitration timeout expires.
// - Bit 31 sets when an initiator transaction completes cleanly.
// - Arb-lost, timeout and refused flags may set with boot failure.
// - Writing one clears a flag, zero keeps it; software reads first.
// - Per-bit enable register with the status layout gates the request.
// - Set register forces a flag's events; forced flags show even when the event is blocked.
`include "twes_params.svh"
module twes_event_status (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   block_soft_reset,
  input  wire logic                   slave_write_permit,
  input  wire logic                   slave_read_permit,
  input  wire twes_pkg::twes_events_s ev,
  input  wire twes_pkg::twes_bus_req_s bus_req,
  output logic                        bus_ack,
  output logic [31:0]                 bus_rdata,
  output logic                        serial_irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input logic [19:0] a, input logic [19:0] off);
    hit = bus_req.sel && (a == off);
  endfunction : hit

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] serial_event_status_reg;
  logic [31:0] serial_event_status_next;
  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic        outbox_loaded_reg;
  logic        outbox_loaded_next;
  logic        bus_ack_reg;
  logic        bus_ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        irq_reg;
  logic        irq_next;
  logic [31:0] raw_events;
  logic [31:0] forced;
  logic [31:0] clr;

  // ****************************************************************
  // Event collection
  // ****************************************************************
  always_comb begin
    raw_events = 32'h0000_0000;
    raw_events[`TWES_OUTBOX_DRAINED]  = ev.outbox_read &&
                                        (outbox_loaded_reg || ev.outbox_loaded);
    raw_events[`TWES_INBOX_FILLED]    = ev.inbox_write;
    raw_events[`TWES_BOOT_FAILED]     = ev.boot_fail;
    raw_events[`TWES_BOOT_DONE]       = ev.boot_ok || ev.boot_disabled;
    raw_events[`TWES_TGT_ERROR]       = ev.tgt_abort;
    raw_events[`TWES_TGT_WRITE]       = ev.tgt_wdata_write && slave_write_permit;
    raw_events[`TWES_TGT_READ]        = ev.tgt_rdata_read && slave_read_permit;
    raw_events[`TWES_TGT_DONE]        = ev.tgt_ok;
    raw_events[`TWES_INI_DIAG]        = ev.ini_diag;
    // Engine may pulse these alongside boot failure; each is simply latched
    raw_events[`TWES_INI_ARB_LOST]    = ev.ini_arb_lost;
    raw_events[`TWES_INI_TIMEOUT]     = ev.ini_timeout;
    raw_events[`TWES_INI_REFUSED]     = ev.ini_nack;
    raw_events[`TWES_INI_ARB_TIMEOUT] = ev.ini_arb_timeout;
    raw_events[`TWES_INI_DONE]        = ev.ini_ok;
  end

  // ****************************************************************
  // Register bus decode and next state
  // ****************************************************************
  always_comb begin
    forced   = 32'h0000_0000;
    clr      = 32'h0000_0000;
    enable_next = enable_reg;
    outbox_loaded_next = outbox_loaded_reg;
    if (ev.outbox_loaded) begin
      outbox_loaded_next = 1'b1;
    end else if (ev.outbox_read) begin
      outbox_loaded_next = 1'b0;
    end
    // Only the internal bus port reaches these registers
    if (bus_req.wr && hit(bus_req.addr, `TWES_STATUS_OFFSET)) begin
      clr = bus_req.wdata & `TWES_IMPL_MASK;
    end
    if (bus_req.wr && hit(bus_req.addr, `TWES_ENABLE_OFFSET)) begin
      enable_next = bus_req.wdata & `TWES_IMPL_MASK;
    end
    if (bus_req.wr && hit(bus_req.addr, `TWES_SET_OFFSET)) begin
      // No underlying-event masking exists here, so every forced bit shows
      forced = bus_req.wdata & `TWES_IMPL_MASK;
    end
    // Set wins over a same-cycle clear so no event is lost
    serial_event_status_next = ((serial_event_status_reg & ~clr) | raw_events | forced)
                               & `TWES_IMPL_MASK;
    if (block_soft_reset) begin
      serial_event_status_next = `TWES_STATUS_RESET;
      outbox_loaded_next = 1'b0;
    end
    irq_next = |(serial_event_status_next & enable_next);
    bus_ack_next = bus_req.sel;
    rdata_next = 32'h0000_0000;
    if (bus_req.sel && !bus_req.wr) begin
      if (hit(bus_req.addr, `TWES_STATUS_OFFSET)) begin
        rdata_next = serial_event_status_reg;
      end else if (hit(bus_req.addr, `TWES_ENABLE_OFFSET)) begin
        rdata_next = enable_reg;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_event_status_reg <= `TWES_STATUS_RESET;
      enable_reg              <= `TWES_ENABLE_RESET;
      outbox_loaded_reg       <= 1'b0;
      bus_ack_reg             <= 1'b0;
      rdata_reg               <= 32'h0000_0000;
      irq_reg                 <= 1'b0;
    end else begin
      serial_event_status_reg <= serial_event_status_next;
      enable_reg              <= enable_next;
      outbox_loaded_reg       <= outbox_loaded_next;
      bus_ack_reg             <= bus_ack_next;
      rdata_reg               <= rdata_next;
      irq_reg                 <= irq_next;
    end
  end

  assign bus_ack    = bus_ack_reg;
  assign bus_rdata  = rdata_reg;
  assign serial_irq = irq_reg;

endmodule : twes_event_status

// ---- src/twes_params.svh ----
// Offsets, field positions, reset values and masks of the serial event status block
`ifndef TWES_PARAMS_SVH
`define TWES_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses on the internal register bus)
// ****************************************************************
`define TWES_ADDR_W           20
`define TWES_STATUS_OFFSET    20'h1d11c
`define TWES_ENABLE_OFFSET    20'h1d120
`define TWES_SET_OFFSET       20'h1d124

// ****************************************************************
// Field positions
// ****************************************************************
`define TWES_OUTBOX_DRAINED   6
`define TWES_INBOX_FILLED     7
`define TWES_BOOT_FAILED      14
`define TWES_BOOT_DONE        15
`define TWES_TGT_ERROR        20
`define TWES_TGT_WRITE        21
`define TWES_TGT_READ         22
`define TWES_TGT_DONE         23
`define TWES_INI_DIAG         24
`define TWES_INI_ARB_LOST     27
`define TWES_INI_TIMEOUT      28
`define TWES_INI_REFUSED      29
`define TWES_INI_ARB_TIMEOUT  30
`define TWES_INI_DONE         31

// ****************************************************************
// Reset values and implemented-bit mask
// ****************************************************************
`define TWES_STATUS_RESET     32'h0000_0000
`define TWES_ENABLE_RESET     32'h0000_0000
`define TWES_IMPL_MASK        32'hf9f0_c0c0

`endif

// ---- src/twes_pkg.sv ----
// Types shared by the serial event status block
package twes_pkg;

  // ****************************************************************
  // Event pulses from the engines, one cycle each
  // ****************************************************************
  typedef struct packed {
    logic outbox_read;
    logic outbox_loaded;
    logic inbox_write;
    logic boot_fail;
    logic boot_ok;
    logic boot_disabled;
    logic tgt_abort;
    logic tgt_wdata_write;
    logic tgt_rdata_read;
    logic tgt_ok;
    logic ini_diag;
    logic ini_arb_lost;
    logic ini_timeout;
    logic ini_nack;
    logic ini_arb_timeout;
    logic ini_ok;
  } twes_events_s;

  // ****************************************************************
  // Internal register bus request
  // ****************************************************************
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [19:0] addr;
    logic [31:0] wdata;
  } twes_bus_req_s;

  typedef logic [31:0] twes_word_t;

endpackage : twes_pkg

// ---- tb/twes_event_status_props.sv ----
// Port checker for the serial event status block
`include "twes_params.svh"
module twes_props (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    block_soft_reset,
  input wire logic                    slave_write_permit,
  input wire logic                    slave_read_permit,
  input wire twes_pkg::twes_events_s  ev,
  input wire twes_pkg::twes_bus_req_s bus_req,
  input wire logic                    bus_ack,
  input wire logic [31:0]             bus_rdata,
  input wire logic                    serial_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] en_reg;
  logic [31:0] en_next;
  // Enable mirror; reserved bits kept too, which only weakens the zero-enable check
  always_comb en_next = (bus_req.sel && bus_req.wr && bus_req.addr == `TWES_ENABLE_OFFSET) ?
                        bus_req.wdata : en_reg;
  always_ff @(posedge clk) en_reg <= rst_n ? en_next : 32'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (bus_ack == $past(bus_req.sel))
    else $error("ack not one cycle after request");
  a_reserved_read_zero: assert property (bus_ack |-> (bus_rdata & ~`TWES_IMPL_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  a_write_reads_zero: assert property (bus_req.sel && (bus_req.wr ||
    bus_req.addr == `TWES_SET_OFFSET) |=> bus_rdata == 32'h0) else $error("write data nonzero");
  a_soft_reset_empty: assert property (block_soft_reset && $past(block_soft_reset) &&
    bus_req.sel && !bus_req.wr && bus_req.addr == `TWES_STATUS_OFFSET |=> bus_rdata == 32'h0)
    else $error("status nonzero in soft reset");
  a_soft_reset_quiet: assert property (block_soft_reset |=> !serial_irq)
    else $error("request during soft reset");
  a_disabled_quiet: assert property (en_reg == 32'h0 |-> !serial_irq)
    else $error("request with all enables off");
  a_enabled_raises: assert property (ev.ini_ok && en_reg[31] && !block_soft_reset &&
    !bus_req.sel |=> serial_irq) else $error("enabled event gave no request");
  a_clear_all_drops: assert property (bus_req.sel && bus_req.wr &&
    bus_req.addr == `TWES_STATUS_OFFSET && bus_req.wdata == 32'hffff_ffff && ev == '0
    |=> !serial_irq) else $error("request kept after full clear");
  c_status_seen: cover property (bus_ack && bus_rdata != 32'h0);
  c_irq_rise: cover property ($rose(serial_irq));
  c_soft_reset_end: cover property ($fell(block_soft_reset));
endmodule : twes_props
bind twes_event_status twes_props u_props (.clk(clk), .rst_n(rst_n),
  .block_soft_reset(block_soft_reset), .slave_write_permit(slave_write_permit),
  .slave_read_permit(slave_read_permit), .ev(ev), .bus_req(bus_req), .bus_ack(bus_ack),
  .bus_rdata(bus_rdata), .serial_irq(serial_irq));

// ---- tb/twes_event_status_tb.sv ----
// Self-checking bench for the serial event status block
`include "twes_params.svh"
module twes_event_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] ST = `TWES_STATUS_OFFSET;
  localparam logic [19:0] EN = `TWES_ENABLE_OFFSET;
  localparam logic [19:0] SET = `TWES_SET_OFFSET;
  logic clk = 1'b0, rst_n = 1'b0, srst = 1'b0, wperm = 1'b1, rperm = 1'b1, ack, irq;
  twes_pkg::twes_events_s  ev = '0;
  twes_pkg::twes_bus_req_s req = '0;
  twes_pkg::twes_word_t    rd, m, rdata;
  logic [7:0] rises, r0;
  int err_total = 0, n_tests = 0;
  logic [15:0] evt [15] = '{16'hc000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200,
    16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
  int pos [15] = '{6, 7, 14, 15, 15, 20, 21, 22, 23, 24, 27, 28, 29, 30, 31};
  twes_event_status dut (.clk(clk), .rst_n(rst_n), .block_soft_reset(srst),
    .slave_write_permit(wperm), .slave_read_permit(rperm), .ev(ev), .bus_req(req),
    .bus_ack(ack), .bus_rdata(rdata), .serial_irq(irq));
  twes_intc_model intc (.clk(clk), .rst_n(rst_n), .serial_irq(irq), .rise_cnt(rises));
  initial forever #50 clk = ~clk;
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input twes_pkg::twes_word_t exp, got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  // One-cycle request; the answer is taken at the edge where ack is seen
  task automatic bus(input logic w, input logic [19:0] a, input twes_pkg::twes_word_t d);
    int n;
    @(posedge clk) req <= '{1'b1, w, a, d};
    @(posedge clk) req.sel <= 1'b0;
    for (n = 0; n < 4 && ack !== 1'b1; n++) @(posedge clk);
    rd = rdata;
    if (n == 4) begin
      err_total++;
      tally_and_finish();
    end
  endtask : bus
  task automatic rchk(input string what, input logic [19:0] a, input twes_pkg::twes_word_t e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask : rchk
  task automatic pulse(input logic [15:0] v);
    @(posedge clk) ev <= v;
    @(posedge clk) ev <= '0;
  endtask : pulse
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk("status", ST, 32'h0);
    rchk("enable", EN, 32'h0);
    rchk("set", SET, 32'h0);
    rchk("unmapped", 20'h1d128, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 15; i++) begin
      m = 32'h1 << pos[i];
      pulse(evt[i]);
      rchk("flag", ST, m);
      chk("irq", 32'h0, {31'h0, irq});
      bus(1'b1, ST, ~m);
      rchk("keep", ST, m);
      bus(1'b1, ST, m);
    end
    pulse(16'h1008);
    rchk("boot fail", ST, 32'h1000_4000);
    bus(1'b1, ST, 32'hffff_ffff);
    $display("test events done");
    wperm <= 1'b0;
    rperm <= 1'b0;
    pulse(16'h0180);
    rchk("gated", ST, 32'h0);
    pulse(16'h4000);
    pulse(16'h8000);
    rchk("outbox", ST, 32'h0000_0040);
    bus(1'b1, ST, 32'h0000_0040);
    pulse(16'h8000);
    rchk("outbox empty", ST, 32'h0);
    $display("test gating done");
    bus(1'b1, EN, 32'hffff_ffff);
    rchk("enable", EN, `TWES_IMPL_MASK);
    r0 = rises;
    bus(1'b1, SET, 32'h8000_0000);
    rchk("forced", ST, 32'h8000_0000);
    chk("intc", {24'h0, r0 + 8'h01}, {24'h0, rises});
    bus(1'b1, ST, 32'hffff_ffff);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(16'h0001);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, EN, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, SET, 32'h060f_3f3f);
    rchk("reserved", ST, 32'h8000_0000);
    $display("test request done");
    bus(1'b1, SET, `TWES_IMPL_MASK);
    srst <= 1'b1;
    pulse(16'hffff);
    rchk("in reset", ST, 32'h0);
    srst <= 1'b0;
    rchk("released", ST, 32'h0);
    pulse(16'h0001);
    rchk("fresh", ST, 32'h8000_0000);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule : twes_event_status_tb

// ---- tb/twes_intc_model.sv ----
// Interrupt controller stand-in that counts new request assertions
module twes_intc_model (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  serial_irq,
  output logic [7:0] rise_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_reg;
  // Level input; only a fresh assertion counts, as a pending latch would see it
  always_ff @(posedge clk) begin
    last_reg <= rst_n & serial_irq;
    rise_cnt <= !rst_n ? 8'h00 : rise_cnt + {7'h00, serial_irq & ~last_reg};
  end
endmodule : twes_intc_model
